// file: hw/calc_key_params.svh
// Constants of the calculator key sequencer: offsets, fields and timings.
`ifndef CALC_KEY_PARAMS_SVH
`define CALC_KEY_PARAMS_SVH

`define CLK_PERIOD_PS    32'h00000FA0
`define DIGIT_TIME_PS    32'h04F27AC0
`define DIGITS_PER_WORD  4'h9
`define LAST_DIGIT       4'h8
`define ENTRY_WORDS      5'h09
`define RELEASE_WORDS    5'h10
`define CUTOFF_S         64'h0000000000000023
`define PS_PER_S         64'h000000E8D4A51000
`define SCALE            96'sh64
`define TEN              96'sh0A
`define MAX_MAG          96'sh5F5E0FF
`define MAX_ENTRY_DIGITS 4'h8
`define CORRUPT_VAL      48'sh7FFF_FFFF_FFFF
`define CODE_POINT       6'h0A
`define CODE_LAST_DIGIT  6'h09

`define OFF_X_LO   8'h00
`define OFF_X_HI   8'h04
`define OFF_Y_LO   8'h08
`define OFF_Y_HI   8'h0C
`define OFF_A_LO   8'h10
`define OFF_A_HI   8'h14
`define OFF_M_LO   8'h18
`define OFF_M_HI   8'h1C
`define OFF_FIN_LO 8'h20
`define OFF_FIN_HI 8'h24
`define OFF_STATUS 8'h28
`define OFF_I_LO   8'h2C
`define OFF_N_LO   8'h30

`endif

// file: hw/calc_key_pkg.sv
// Types shared by the calculator key sequencer.
`default_nettype none
package calc_key_pkg;
   typedef logic signed [47:0] num_t;
   typedef logic signed [95:0] wide_t;

   typedef enum logic [2:0] {
      KS_IDLE    = 3'b000,
      KS_ENTRY   = 3'b001,
      KS_EXEC    = 3'b010,
      KS_HELD    = 3'b011,
      KS_RELEASE = 3'b100
   } key_st_e;

   typedef enum logic [1:0] {
      MODE_CONST_MUL = 2'b00,
      MODE_CHAIN_MUL = 2'b01,
      MODE_CONST_DIV = 2'b10,
      MODE_CHAIN_DIV = 2'b11
   } calc_mode_e;

   typedef enum logic [2:0] {
      LAST_OTHER   = 3'b000,
      LAST_NUM     = 3'b001,
      LAST_ADDSUB  = 3'b010,
      LAST_RECALL  = 3'b011,
      LAST_MADD_AS = 3'b100
   } last_e;

   typedef enum logic [4:0] {
      KEY_DIGIT = 5'b00000,
      KEY_POINT = 5'b00001,
      KEY_CS    = 5'b00010,
      KEY_CLEAR = 5'b00011,
      KEY_ADD   = 5'b00100,
      KEY_SUB   = 5'b00101,
      KEY_MUL   = 5'b00110,
      KEY_DIV   = 5'b00111,
      KEY_EQ    = 5'b01000,
      KEY_PCT   = 5'b01001,
      KEY_MADD  = 5'b01010,
      KEY_RECALL = 5'b01011,
      KEY_EXCH  = 5'b01100,
      KEY_POWER = 5'b01101,
      KEY_PRESENT_FUTURE = 5'b01110,
      KEY_SINKING_FUND   = 5'b01111,
      KEY_LOAN  = 5'b10000,
      KEY_NOP   = 5'b10001
   } key_e;

   typedef struct packed {
      key_st_e    st;
      logic [15:0] dcnt;
      logic [3:0] digit;
      logic [4:0] wcnt;
      logic       phase;
      logic       lvl;
      logic [3:0] capDigit;
      logic [1:0] capRet;
      logic [15:0] ccnt;
      logic       cutoff;
      logic       err;
      calc_mode_e mode;
      last_e      last;
      logic       entering;
      logic       pointSeen;
      logic [3:0] cnt;
      logic [3:0] frac;
      logic [26:0] dig;
      num_t       x;
      num_t       y;
      num_t       a;
      num_t       m;
      num_t       i;
      num_t       n;
      logic [63:0] fin;
      logic       ack;
      logic [31:0] dat;
   } state_s;
endpackage
`default_nettype wire

// file: hw/calculator_key_sequencer.sv
// Key debounce, ready handshake, display cutoff and arithmetic key sequencing.
`default_nettype none
`include "calc_key_params.svh"

// Overview of operation
// - Closure starts counter; key acts after nine word times still high.
// - Release of accepted key runs sixteen word time-out before idle.
// - Sample every second word time; invalid level resets, reverts state.
// - Thirty-five idle seconds blank display; any key press restores it.
// - Ready high idle and entry; low from acceptance until release time-out ends.
// - Divide by zero or magnitude above 99999999 sets error.
// - Next key press of any kind clears the error indication.
// - Add/sub error clears entry, keeps it in addend; mul/div clear entry.
// - Financial key overflow clears entry, corrupts period, interest, addend.
// - Negative base to power: error, clear entry, exponent to operand.
// - Memory-add overflow corrupts memory, clears entry, errors, halts.
// - Terminated multiply/divide keeps constant factor in operand register.
// - Chain result goes to entry and operand; new number replaces entry.
// - Clear after number or recall clears entry; else entry, operand, addend.
// - Digits shift in up to eight; addend takes entry after add/sub.
// - Point first clears, goes leftmost; last point press in entry counts.
// - Add: first gives addend plus entry; repeat adds addend to entry.
// - Subtract: first gives addend minus entry; repeat subtracts addend.
// - Multiply/divide copy entry to operand or apply pending chain operation.
// - Equals computes by mode; chain divide moves entry into operand.
// - Equals truncates to two places and clears addend.
// - Percent divides entry by 100 into addend first, then equals.
// - Twenty-six keys decode from four returns by nine strobes.
// - Power-up reset clears every register including memory.
module calculator_key_sequencer
   import calc_key_pkg::*;
#(
   parameter int unsigned DIGIT_CYCLES = `DIGIT_TIME_PS / `CLK_PERIOD_PS,
   parameter int unsigned CUTOFF_WORDS = int'(`CUTOFF_S * `PS_PER_S /
      (64'(`DIGIT_TIME_PS) * 64'(`DIGITS_PER_WORD)))
) (
   input  wire logic        clk_sys,
   input  wire logic        srst,
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [7:0]  adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   output logic             ack_o,
   output logic [31:0]      dat_o,
   input  wire logic        keyReturnLine1,
   input  wire logic        keyReturnLine2,
   input  wire logic        keyReturnLine3,
   input  wire logic        keyReturnLine4,
   output logic [8:0]       digitStrobe,
   output logic             ready,
   output logic             displayBlank,
   output logic             errorShow
);

   state_s r;
   state_s nx;

   function automatic key_e keyOf(input logic [5:0] code);
      if (code <= `CODE_LAST_DIGIT) begin
         return KEY_DIGIT;
      end
      unique case (code)
         6'h0A:   return KEY_POINT;
         6'h0B:   return KEY_CS;
         6'h0C:   return KEY_CLEAR;
         6'h0D:   return KEY_ADD;
         6'h0E:   return KEY_SUB;
         6'h0F:   return KEY_MUL;
         6'h10:   return KEY_DIV;
         6'h11:   return KEY_EQ;
         6'h12:   return KEY_PCT;
         6'h13:   return KEY_MADD;
         6'h14:   return KEY_RECALL;
         6'h15:   return KEY_EXCH;
         6'h16:   return KEY_POWER;
         6'h17:   return KEY_PRESENT_FUTURE;
         6'h18:   return KEY_SINKING_FUND;
         6'h19:   return KEY_LOAN;
         default: return KEY_NOP;
      endcase
   endfunction

   function automatic logic ovf(input wide_t v);
      return (v > `MAX_MAG * `SCALE) || (v < -(`MAX_MAG * `SCALE));
   endfunction

   function automatic wide_t widen(input num_t v);
      return wide_t'(v);
   endfunction

   function automatic wide_t mulFx(input num_t p, input num_t q);
      return widen(p) * widen(q) / `SCALE;
   endfunction

   // Callers guard against a zero divisor before using the quotient.
   function automatic wide_t divFx(input num_t p, input num_t q);
      if (q == '0) begin
         return '0;
      end
      return widen(p) * `SCALE / widen(q);
   endfunction

   function automatic num_t scaleEntry(input logic [26:0] dig,
                                       input logic [3:0]  frac);
      wide_t p;
      p = 96'sh1;
      for (int k = 0; k < 8; k++) begin
         if (4'(k) < frac) begin
            p = p * `TEN;
         end
      end
      return num_t'(wide_t'({69'h0, dig}) * `SCALE / p);
   endfunction

   function automatic logic [31:0] mergeBytes(input logic [31:0] old,
                                              input logic [31:0] dat,
                                              input logic [3:0]  sel);
      logic [31:0] o;
      o = old;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            o[8*b +: 8] = dat[8*b +: 8];
         end
      end
      return o;
   endfunction

   logic [3:0]  retVec;
   logic [1:0]  firstRet;
   logic        digitTick;
   logic        wordTick;
   logic [5:0]  code;
   key_e        key;
   logic [3:0]  dval;
   logic        addCtx;
   wide_t       res;
   logic        bad;
   num_t        fx;

   assign retVec = {keyReturnLine4, keyReturnLine3,
                    keyReturnLine2, keyReturnLine1};

   always_comb begin
      firstRet = 2'h0;
      for (int k = 3; k >= 0; k--) begin
         if (retVec[k]) begin
            firstRet = 2'(k);
         end
      end
   end

   always_comb begin
      nx = r;
      res = '0;
      bad = 1'b0;
      fx = r.x;
      digitTick = (r.dcnt == 16'(DIGIT_CYCLES - 1));
      wordTick = digitTick && (r.digit == `LAST_DIGIT);
      code = {r.capDigit, r.capRet};
      key = keyOf(code);
      dval = code[3:0];
      addCtx = (r.last == LAST_ADDSUB) || (r.last == LAST_MADD_AS);

      // Scan timing: digit strobes step on the digit tick.
      nx.dcnt = digitTick ? 16'h0 : r.dcnt + 16'h1;
      if (digitTick) begin
         nx.digit = (r.digit == `LAST_DIGIT) ? 4'h0 : r.digit + 4'h1;
      end
      if (r.digit == r.capDigit) begin
         nx.lvl = retVec[r.capRet];
      end
      if (wordTick && !r.cutoff) begin
         nx.ccnt = r.ccnt + 16'h1;
         if (r.ccnt + 16'h1 >= 16'(CUTOFF_WORDS)) begin
            nx.cutoff = 1'b1;
         end
      end

      unique case (r.st)
         KS_IDLE: begin
            if (|retVec) begin
               nx.st = KS_ENTRY;
               nx.capDigit = r.digit;
               nx.capRet = firstRet;
               nx.lvl = 1'b1;
               nx.wcnt = 5'h0;
               nx.phase = 1'b0;
            end
         end
         KS_ENTRY: begin
            if (wordTick) begin
               nx.wcnt = r.wcnt + 5'h1;
               nx.phase = !r.phase;
               if (r.phase && !r.lvl) begin
                  nx.st = KS_IDLE;
               end else if (r.wcnt + 5'h1 >= `ENTRY_WORDS && r.lvl) begin
                  nx.st = KS_EXEC;
               end
            end
         end
         KS_EXEC: begin
            nx.st = KS_HELD;
            nx.ccnt = 16'h0;
            nx.cutoff = 1'b0;
            if (r.err) begin
               nx.err = 1'b0;
            end else begin
               unique case (key)
                  KEY_DIGIT: begin
                     if (!r.entering) begin
                        if (addCtx) begin
                           nx.a = r.x;
                        end
                        nx.entering = 1'b1;
                        nx.pointSeen = 1'b0;
                        nx.dig = 27'(dval);
                        nx.cnt = 4'h1;
                        nx.frac = 4'h0;
                     end else if (r.cnt < `MAX_ENTRY_DIGITS) begin
                        nx.dig = 27'(r.dig * 27'hA + 27'(dval));
                        nx.cnt = r.cnt + 4'h1;
                        nx.frac = r.pointSeen ? r.frac + 4'h1 : r.frac;
                     end
                     nx.x = scaleEntry(nx.dig, nx.frac);
                     nx.last = LAST_NUM;
                  end
                  KEY_POINT: begin
                     if (!r.entering) begin
                        if (addCtx) begin
                           nx.a = r.x;
                        end
                        nx.entering = 1'b1;
                        nx.dig = 27'h0;
                        nx.cnt = 4'h0;
                     end
                     // A later press moves the point behind the last digit.
                     nx.pointSeen = 1'b1;
                     nx.frac = 4'h0;
                     nx.x = scaleEntry(nx.dig, 4'h0);
                     nx.last = LAST_NUM;
                  end
                  KEY_CS: begin
                     nx.x = -r.x;
                     nx.entering = 1'b0;
                     nx.last = LAST_OTHER;
                  end
                  KEY_CLEAR: begin
                     nx.x = '0;
                     if (r.last != LAST_NUM && r.last != LAST_RECALL) begin
                        nx.y = '0;
                        nx.a = '0;
                        nx.mode = MODE_CONST_MUL;
                     end
                     nx.last = LAST_OTHER;
                  end
                  KEY_ADD, KEY_SUB: begin
                     if (r.last != LAST_ADDSUB) begin
                        res = (key == KEY_ADD) ? widen(r.a) + widen(r.x)
                                               : widen(r.a) - widen(r.x);
                        nx.a = r.x;
                     end else begin
                        res = (key == KEY_ADD) ? widen(r.x) + widen(r.a)
                                               : widen(r.x) - widen(r.a);
                     end
                     bad = ovf(res);
                     nx.x = bad ? num_t'(0) : num_t'(res);
                     nx.last = LAST_ADDSUB;
                  end
                  KEY_MUL, KEY_DIV: begin
                     if (r.mode == MODE_CONST_MUL ||
                         r.mode == MODE_CONST_DIV) begin
                        nx.y = r.x;
                     end else begin
                        bad = (r.mode == MODE_CHAIN_DIV) && (r.x == '0);
                        res = (r.mode == MODE_CHAIN_MUL) ? mulFx(r.x, r.y)
                                                         : divFx(r.y, r.x);
                        bad = bad || ovf(res);
                        nx.x = bad ? num_t'(0) : num_t'(res);
                        nx.y = bad ? r.y : num_t'(res);
                     end
                     nx.mode = (key == KEY_MUL) ? MODE_CHAIN_MUL
                                                : MODE_CHAIN_DIV;
                     nx.last = LAST_OTHER;
                  end
                  KEY_EQ, KEY_PCT: begin
                     if (key == KEY_PCT) begin
                        fx = num_t'(widen(r.x) / `SCALE);
                        nx.a = fx;
                     end else begin
                        nx.a = '0;
                     end
                     unique case (r.mode)
                        MODE_CONST_MUL, MODE_CHAIN_MUL: begin
                           res = mulFx(fx, r.y);
                           nx.mode = MODE_CONST_MUL;
                        end
                        MODE_CONST_DIV: begin
                           bad = (r.y == '0);
                           res = divFx(fx, r.y);
                        end
                        MODE_CHAIN_DIV: begin
                           bad = (fx == '0);
                           res = divFx(r.y, fx);
                           nx.y = bad ? r.y : fx;
                           nx.mode = MODE_CONST_DIV;
                        end
                     endcase
                     // Values carry two fixed decimals, so the result is
                     // already truncated to two places.
                     bad = bad || ovf(res);
                     nx.x = bad ? num_t'(0) : num_t'(res);
                     nx.last = LAST_OTHER;
                  end
                  KEY_MADD: begin
                     res = widen(r.m) + widen(r.x);
                     bad = ovf(res);
                     nx.m = bad ? `CORRUPT_VAL : num_t'(res);
                     nx.x = bad ? num_t'(0) : r.x;
                     nx.last = addCtx ? LAST_MADD_AS : LAST_OTHER;
                  end
                  KEY_RECALL: begin
                     nx.x = r.m;
                     if (r.last == LAST_RECALL) begin
                        nx.m = '0;
                        nx.last = LAST_OTHER;
                     end else begin
                        if (addCtx) begin
                           nx.a = r.x;
                        end
                        nx.last = LAST_RECALL;
                     end
                  end
                  KEY_EXCH: begin
                     nx.x = r.y;
                     nx.y = r.x;
                     nx.last = LAST_OTHER;
                  end
                  KEY_POWER, KEY_PRESENT_FUTURE, KEY_SINKING_FUND,
                  KEY_LOAN: begin
                     // The numeric result is supplied by software.
                     res = wide_t'($signed(r.fin));
                     if (key == KEY_POWER && r.y < 0) begin
                        bad = 1'b1;
                        nx.x = '0;
                        nx.y = r.x;
                     end else if (ovf(res)) begin
                        bad = 1'b1;
                        nx.x = '0;
                        nx.i = `CORRUPT_VAL;
                        nx.n = `CORRUPT_VAL;
                        nx.a = `CORRUPT_VAL;
                     end else begin
                        nx.x = num_t'(res);
                        nx.a = '0;
                        nx.mode = MODE_CONST_MUL;
                     end
                     nx.last = LAST_OTHER;
                  end
                  KEY_NOP: begin
                     nx.last = LAST_OTHER;
                  end
               endcase
               if (key != KEY_DIGIT && key != KEY_POINT) begin
                  nx.entering = 1'b0;
               end
               if (bad) begin
                  nx.err = 1'b1;
               end
            end
         end
         KS_HELD: begin
            if (r.digit == r.capDigit && !retVec[r.capRet]) begin
               nx.st = KS_RELEASE;
               nx.wcnt = 5'h0;
               nx.phase = 1'b0;
            end
         end
         KS_RELEASE: begin
            if (wordTick) begin
               nx.wcnt = r.wcnt + 5'h1;
               nx.phase = !r.phase;
               if (r.phase && r.lvl) begin
                  nx.st = KS_HELD;
               end else if (r.wcnt + 5'h1 >= `RELEASE_WORDS && !r.lvl) begin
                  nx.st = KS_IDLE;
               end
            end
         end
         default: begin
            nx.st = KS_IDLE;
         end
      endcase

      // Wishbone classic slave: one wait state, write on the ack edge.
      nx.ack = cyc_i && stb_i && !r.ack;
      if (cyc_i && stb_i && !r.ack && !we_i) begin
         unique case ({adr_i[7:2], 2'b00})
            `OFF_X_LO:   nx.dat = r.x[31:0];
            `OFF_X_HI:   nx.dat = 32'(r.x[47:32]);
            `OFF_Y_LO:   nx.dat = r.y[31:0];
            `OFF_Y_HI:   nx.dat = 32'(r.y[47:32]);
            `OFF_A_LO:   nx.dat = r.a[31:0];
            `OFF_A_HI:   nx.dat = 32'(r.a[47:32]);
            `OFF_M_LO:   nx.dat = r.m[31:0];
            `OFF_M_HI:   nx.dat = 32'(r.m[47:32]);
            `OFF_FIN_LO: nx.dat = r.fin[31:0];
            `OFF_FIN_HI: nx.dat = r.fin[63:32];
            `OFF_STATUS: nx.dat = {24'h0, r.entering, r.mode, r.last[1:0],
                                   r.cutoff, r.err, ready};
            `OFF_I_LO:   nx.dat = r.i[31:0];
            `OFF_N_LO:   nx.dat = r.n[31:0];
            default:     nx.dat = 32'h0;
         endcase
      end
      if (cyc_i && stb_i && r.ack && we_i) begin
         if ({adr_i[7:2], 2'b00} == `OFF_FIN_LO) begin
            nx.fin[31:0] = mergeBytes(r.fin[31:0], dat_i, sel_i);
         end
         if ({adr_i[7:2], 2'b00} == `OFF_FIN_HI) begin
            nx.fin[63:32] = mergeBytes(r.fin[63:32], dat_i, sel_i);
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         r <= '0;
      end else begin
         r <= nx;
      end
   end

   assign ready = (r.st == KS_IDLE) || (r.st == KS_ENTRY);
   assign ack_o = r.ack;
   assign dat_o = r.dat;
   assign digitStrobe = 9'h1 << r.digit;
   assign displayBlank = r.cutoff;
   assign errorShow = r.err;

endmodule
`default_nettype wire

// file: dv/calc_key_chk.sv
// Port assertions for the calculator key sequencer.
`default_nettype none
module calc_key_chk #(
   parameter int unsigned DIGIT_CYCLES = 4,
   parameter int unsigned CUTOFF_WORDS = 20
) (
   input wire logic       clk_sys,
   input wire logic       srst,
   input wire logic       cyc_i,
   input wire logic       stb_i,
   input wire logic       ack_o,
   input wire logic       keyReturnLine1,
   input wire logic       keyReturnLine2,
   input wire logic       keyReturnLine3,
   input wire logic       keyReturnLine4,
   input wire logic [8:0] digitStrobe,
   input wire logic       ready,
   input wire logic       errorShow,
   input wire logic       displayBlank
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam int W = 9 * DIGIT_CYCLES;
   logic [15:0] lowCnt_reg;
   logic [15:0] entCnt_reg;
   logic [8:0]  prevStrobe_reg;
   logic [15:0] idleCnt_reg;
   logic        prevReady_reg;
   wire logic   anyRet = keyReturnLine1 | keyReturnLine2 | keyReturnLine3 |
      keyReturnLine4;
   // Saturating, so a long idle after an aborted closure cannot wrap.
   always_ff @(posedge clk_sys) begin
      prevStrobe_reg <= digitStrobe;
      prevReady_reg <= ready;
      // Restarts when a key is accepted, as the cutoff timer does.
      if (srst || (prevReady_reg && !ready))
         idleCnt_reg <= 16'h0000;
      else if (idleCnt_reg != 16'hFFFF)
         idleCnt_reg <= idleCnt_reg + 16'h0001;
      lowCnt_reg <= (srst || ready) ? 16'h0000 : lowCnt_reg + 16'h0001;
      if (srst || !ready)
         entCnt_reg <= 16'h0000;
      else if ((entCnt_reg != 16'h0000 || anyRet) && entCnt_reg != 16'hFFFF)
         entCnt_reg <= entCnt_reg + 16'h0001;
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (srst);
   a_ack_answer:
      assert property (cyc_i && stb_i && !ack_o |=> ack_o)
      else $error("bus request not answered");
   a_ack_pulse:
      assert property (ack_o |=> !ack_o)
      else $error("ack longer than one cycle");
   a_entry_wait:
      assert property ($fell(ready) |-> entCnt_reg >= 16'(8 * W))
      else $error("key accepted too early");
   a_release_wait:
      assert property ($rose(ready) |-> lowCnt_reg >= 16'(15 * W))
      else $error("ready back too early");
   a_strobe_onehot:
      assert property ($onehot(digitStrobe))
      else $error("strobe not one-hot");
   a_strobe_step:
      assert property (digitStrobe != prevStrobe_reg |-> digitStrobe ==
         {prevStrobe_reg[7:0], prevStrobe_reg[8]} ##1 $stable(digitStrobe)[*3])
      else $error("strobe stepped wrongly");
   a_blank_restore:
      assert property ($fell(ready) |-> ##2 !displayBlank)
      else $error("display not restored by key");
   a_blank_late:
      assert property ($rose(displayBlank) |->
         idleCnt_reg >= 16'((CUTOFF_WORDS - 1) * W))
      else $error("display blanked too early");
   a_error_cause:
      assert property ($rose(errorShow) |-> !ready)
      else $error("error raised without a key");
   a_error_clear:
      assert property (errorShow && $fell(ready) |-> ##2 !errorShow)
      else $error("error not cleared by key");
endmodule
bind calculator_key_sequencer calc_key_chk #(
   .DIGIT_CYCLES(DIGIT_CYCLES),
   .CUTOFF_WORDS(CUTOFF_WORDS)
) i_calc_key_chk (
   .clk_sys, .srst, .cyc_i, .stb_i, .ack_o, .keyReturnLine1, .keyReturnLine2,
   .keyReturnLine3, .keyReturnLine4, .digitStrobe, .ready, .errorShow,
   .displayBlank
);
`default_nettype wire

// file: dv/key_matrix_model.sv
// Passive key matrix closing one return line while its strobe is active.
`default_nettype none
module key_matrix_model (
   input  wire logic       pressed,
   input  wire logic [5:0] keyCode,
   input  wire logic [8:0] digitStrobe,
   output logic      [3:0] keyReturn
);
   timeunit 1ns;
   timeprecision 1ps;
   always_comb begin
      keyReturn = 4'h0;
      // An open switch leaves every return line on its pull-down.
      if (pressed && digitStrobe[keyCode / 6'h04])
         keyReturn[keyCode % 6'h04] = 1'b1;
   end
endmodule
`default_nettype wire

// file: dv/calculator_key_sequencer_tb.sv
// Self-checking bench for the calculator key sequencer.
`default_nettype none
module calculator_key_sequencer_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int W = 36;
   logic        clk_sys = 1'b0;
   logic        srst = 1'b1;
   logic        cyc_i = 1'b0;
   logic        stb_i = 1'b0;
   logic        we_i = 1'b0;
   logic [7:0]  adr_i = 8'h00;
   logic [31:0] dat_i = 32'h00000000;
   logic [31:0] dat_o;
   logic        ack_o;
   logic [3:0]  keyReturn;
   logic [8:0]  digitStrobe;
   logic        ready;
   logic        displayBlank;
   logic        errorShow;
   logic        pressed = 1'b0;
   logic [5:0]  keyCode = 6'h00;
   logic [31:0] lfsr = 32'h66810D09;
   int          mismatches = 0;
   int          n_checks = 0;
   initial forever #2 clk_sys = ~clk_sys;
   calculator_key_sequencer #(.DIGIT_CYCLES(4), .CUTOFF_WORDS(20))
      i_calculator_key_sequencer (.clk_sys, .srst, .cyc_i, .stb_i, .we_i,
      .adr_i, .sel_i(4'hF), .dat_i, .ack_o, .dat_o, .digitStrobe, .ready,
      .keyReturnLine1(keyReturn[0]), .keyReturnLine2(keyReturn[1]),
      .keyReturnLine3(keyReturn[2]), .keyReturnLine4(keyReturn[3]),
      .displayBlank, .errorShow);
   key_matrix_model i_key_matrix_model (.pressed, .keyCode, .digitStrobe,
      .keyReturn);
   function automatic logic [31:0] rnd();
      lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
      return lfsr;
   endfunction
   task automatic conclude(input bit hung);
      if (hung) mismatches++;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] adr,
                      output logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_sys);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= adr;
      dat_i <= rnd();
      do @(posedge clk_sys); while (ack_o !== 1'b1 && ++n < 50);
      d = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      if (n >= 50) conclude(1'b1);
   endtask
   task automatic rd(input logic [7:0] adr, input int exp);
      logic [31:0] d;
      bus(1'b0, adr, d);
      check(d, 32'(exp));
   endtask
   task automatic key(input int c);
      int n;
      n = 0;
      @(posedge clk_sys);
      keyCode <= 6'(c);
      pressed <= 1'b1;
      do @(posedge clk_sys); while (ready !== 1'b0 && ++n < 20 * W);
      if (n >= 20 * W) conclude(1'b1);
      check(32'(n > 8 * W), 32'h1);
      pressed <= 1'b0;
      n = 0;
      do @(posedge clk_sys); while (ready !== 1'b1 && ++n < 40 * W);
      if (n >= 40 * W) conclude(1'b1);
      check(32'(n > 15 * W), 32'h1);
   endtask
   initial begin
      logic [31:0] dd;
      int x;
      int n;
      repeat (16) @(posedge clk_sys);
      srst <= 1'b0;
      rd(8'hF0, 0);
      x = 1 + int'(rnd() % 9);
      key(x);
      n = int'(rnd() % 10);
      key(n);
      x = (x * 10 + n) * 100;
      bus(1'b1, 8'h00, dd);
      rd(8'h00, x);
      $display("test entry done");
      key(13);
      key(3);
      key(13);
      key(13);
      rd(8'h00, x + 600);
      rd(8'h10, 300);
      $display("test add done");
      key(12);
      rd(8'h10, 0);
      key(4);
      key(15);
      key(5);
      key(17);
      rd(8'h00, 2000);
      rd(8'h08, 400);
      $display("test multiply done");
      key(6);
      key(16);
      key(0);
      key(17);
      check(32'(errorShow), 32'h1);
      rd(8'h00, 0);
      key(26);
      check(32'(errorShow), 32'h0);
      $display("test error done");
      keyCode <= 6'h07;
      pressed <= 1'b1;
      repeat (3 * W) @(posedge clk_sys);
      pressed <= 1'b0;
      n = 0;
      repeat (12 * W) begin
         @(posedge clk_sys);
         n += int'(ready !== 1'b1);
      end
      check(32'(n), 32'h0);
      rd(8'h00, 0);
      $display("test bounce done");
      repeat (25 * W) @(posedge clk_sys);
      check(32'(displayBlank), 32'h1);
      key(11);
      key(11);
      check(32'(displayBlank), 32'h0);
      rd(8'h00, 0);
      $display("test cutoff done");
      key(2);
      key(10);
      key(5);
      rd(8'h00, 250);
      key(19);
      key(14);
      rd(8'h00, -250);
      rd(8'h10, 250);
      $display("test point done");
      conclude(1'b0);
   end
endmodule
`default_nettype wire
